// ==== ssd_map.svh ====
// Purpose: Offsets, field positions, reset values, glyphs and timing for the status display.
// Assumes: 32-bit Avalon-MM word addressing in bytes, 40 MHz system clock.
// Notes:   Definitions only.
`ifndef SSD_MAP_SVH
`define SSD_MAP_SVH

`define SSD_OFS_CTRL       4'h0
`define SSD_OFS_SWADDR     4'h4
`define SSD_OFS_ADDR       4'h8
`define SSD_OFS_IRQSTAT    4'hC
`define SSD_ADDR_W         4
`define SSD_OFS_IRQMASK    4'h0
`define SSD_ALT_MASK_ADDR  5'h10

`define SSD_CTRL_SRC       0
`define SSD_CTRL_SOFTRST   1
`define SSD_CTRL_TSN       2
`define SSD_CTRL_RESET     3'h4

`define SSD_EV_ALARM       0
`define SSD_EV_WARN        1
`define SSD_EV_LINKA       2
`define SSD_EV_LINKB       3
`define SSD_EV_NET         4
`define SSD_EV_W           5

`define SSD_SWADDR_RESET   8'h01

`define SSD_GLY_BLANK      7'h00
`define SSD_GLY_ABSENT     7'h76
`define SSD_GLY_INITCOMM   7'h40
`define SSD_GLY_PREOP      7'h5C
`define SSD_GLY_SAFEOP     7'h63
`define SSD_GLY_RESERVED   7'h54
`define SSD_GLY_CONNECTED  7'h39
`define SSD_GLY_TEST       7'h78
`define SSD_GLY_CPUERR     7'h73
`define SSD_GLY_UPDATE     7'h3E
`define SSD_GLY_INIT       7'h71
`define SSD_GLY_ADDRSET    7'h6D
`define SSD_GLY_ALARM      7'h77
`define SSD_GLY_BOOT       7'h08

`define SSD_CLK_KHZ        40000
`define SSD_BLINK_HALF_MS  250
`define SSD_DWELL_MS       1000
`define SSD_BLINK_CYC      (`SSD_BLINK_HALF_MS * `SSD_CLK_KHZ)
`define SSD_DWELL_CYC      (`SSD_DWELL_MS * `SSD_CLK_KHZ)

`endif

// ==== ssd_pkg.sv ====
// Purpose: Types shared by the status display block.
// Assumes: Nothing beyond the map header.
// Notes:   Network state codes come from the network controller.
package ssd_pkg;

   typedef enum logic [1:0]
   {
      SSD_BOOT  = 2'b00,
      SSD_NET   = 2'b01,
      SSD_ALARM = 2'b10
   } ssd_view_e;

   typedef enum logic [2:0]
   {
      SSD_NS_ABSENT   = 3'b000,
      SSD_NS_INITCOMM = 3'b001,
      SSD_NS_PREOP    = 3'b010,
      SSD_NS_SAFEOP   = 3'b011,
      SSD_NS_RESERVED = 3'b100,
      SSD_NS_LINKED   = 3'b101
   } ssd_net_e;

endpackage : ssd_pkg

// ==== ssd_tick_gen.sv ====
// Purpose: Blink phase and display dwell timing.
// Assumes: Single clock, counts of at least two cycles.
// Notes:   Both outputs come from flip-flops.
`timescale 1ns/1ps
module ssd_tick_gen
   import ssd_pkg::*;
#(
   parameter int BLINK_CYC = 10000000,
   parameter int DWELL_CYC = 40000000
)
(
   input  wire logic clk_sys,
   input  wire logic rst_b,
   output logic      blinkPhase,
   output logic      dwellTick
);

   logic [31:0] blinkCnt;
   logic [31:0] dwellCnt;

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         blinkCnt   <= 32'h0;
         blinkPhase <= 1'b0;
      end
      else if (blinkCnt == 32'(BLINK_CYC - 1))
      begin
         blinkCnt   <= 32'h0;
         blinkPhase <= ~blinkPhase;
      end
      else
         blinkCnt <= blinkCnt + 32'h1;
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dwellCnt  <= 32'h0;
         dwellTick <= 1'b0;
      end
      else
      begin
         dwellTick <= (dwellCnt == 32'(DWELL_CYC - 1));
         if (dwellCnt == 32'(DWELL_CYC - 1))
            dwellCnt <= 32'h0;
         else
            dwellCnt <= dwellCnt + 32'h1;
      end
   end

endmodule : ssd_tick_gen

// ==== ssd_status_display.sv ====
// Purpose: Front-panel address switches, 7-segment display and status LEDs.
// Assumes: Inputs synchronous to clk_sys; Avalon-MM master obeys waitrequest.
// Notes:   Register map and glyphs live in ssd_map.svh.
// How it works
// R01 - Upper switch high nibble, lower switch low.
// R02 - Switches sampled only at reset or soft-reset.
// R03 - Switch address used only when source is zero.
// R04 - Operator zeroes switches for software addressing.
// R05 - Three-digit variant samples same way.
// R06 - One digit standard, three digits high-speed.
// R07 - Network status shown only after startup completes.
// R08 - Alarm code follows network status in sequence.
// R09 - Distinct glyphs for each time-sensitive network state.
// R10 - Basic mode shows controller-absent glyph for every network state but linked.
// R11 - Distinct glyphs for test, CPU, update, init, addressing.
// R12 - Servo LED off, blinking, or steady by state.
// R13 - Run LED off on alarm, else on.
// R14 - Error LED: warning blinks, alarm steady, alarm wins.
// R15 - Each port link LED follows its link.
// R16 - Decimal point shows servo status while connected.
// R17 - Last two digits show address octet in hex.
// R18 - Blink and dwell times are clock-derived parameters.
`timescale 1ns/1ps
`include "ssd_map.svh"
module ssd_status_display
   import ssd_pkg::*;
#(
   parameter bit THREE_DIGIT = 1'b0,
   parameter int BLINK_CYC   = `SSD_BLINK_CYC,
   parameter int DWELL_CYC   = `SSD_DWELL_CYC
)
(
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic [3:0]  addrSwitchHigh,
   input  wire logic [3:0]  addrSwitchLow,
   input  wire logic        startupDone,
   input  wire logic        servoReady,
   input  wire logic        servoOn,
   input  wire logic        alarmActive,
   input  wire logic        warningActive,
   input  wire logic [11:0] alarmCode,
   input  wire logic [2:0]  netState,
   input  wire logic        testMode,
   input  wire logic        cpuError,
   input  wire logic        fwUpdating,
   input  wire logic        initInProgress,
   input  wire logic        addrSetInProgress,
   input  wire logic        networkPortALink,
   input  wire logic        networkPortBLink,
   output logic      [7:0]  segDigit0,
   output logic      [7:0]  segDigit1,
   output logic      [7:0]  segDigit2,
   output logic      [7:0]  ipOctet,
   output logic             servoIndicator,
   output logic             runIndicator,
   output logic             errorIndicator,
   output logic             portALinkIndicator,
   output logic             portBLinkIndicator,
   output logic             irq
);

   function automatic logic [6:0] hexGlyph(input logic [3:0] n);
      logic [6:0] g;
      g = 7'h00;
      case (n)
         4'h0: g = 7'h3F;  4'h1: g = 7'h06;  4'h2: g = 7'h5B;  4'h3: g = 7'h4F;
         4'h4: g = 7'h66;  4'h5: g = 7'h6D;  4'h6: g = 7'h7D;  4'h7: g = 7'h07;
         4'h8: g = 7'h7F;  4'h9: g = 7'h6F;  4'hA: g = 7'h77;  4'hB: g = 7'h7C;
         4'hC: g = 7'h39;  4'hD: g = 7'h5E;  4'hE: g = 7'h79;  default: g = 7'h71;
      endcase
      return g;
   endfunction : hexGlyph

   logic [2:0]  ctrl;
   logic [7:0]  swAddr;
   logic [7:0]  sampledSw;
   logic        takeSwitch;
   logic [4:0]  irqStat;
   logic [4:0]  irqMask;
   logic [4:0]  prevIn;
   logic        blinkPhase;
   logic        dwellTick;
   logic        busDone;
   ssd_view_e   view;
   ssd_view_e   next_view;

   assign busDone = (avs_read || avs_write) && !avs_waitrequest;

   ssd_tick_gen #(
      .BLINK_CYC (BLINK_CYC),
      .DWELL_CYC (DWELL_CYC)
   ) u_tick (
      .clk_sys    (clk_sys),
      .rst_b      (rst_b),
      .blinkPhase (blinkPhase),
      .dwellTick  (dwellTick)
   ); // [R18]

   // Each request is answered one cycle after it appears, then waitrequest rises again.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         avs_readdata <= 32'h0;
      else if ((avs_read || avs_write) && avs_waitrequest)
      begin
         case (avs_address)
            5'(`SSD_OFS_CTRL):    avs_readdata <= {29'h0, ctrl};
            5'(`SSD_OFS_SWADDR):  avs_readdata <= {24'h0, swAddr};
            5'(`SSD_OFS_ADDR):    avs_readdata <= {16'h0, sampledSw, ipOctet};
            5'(`SSD_OFS_IRQSTAT): avs_readdata <= {27'h0, irqStat};
            `SSD_ALT_MASK_ADDR:   avs_readdata <= {27'h0, irqMask};
            default:              avs_readdata <= 32'h0;
         endcase
      end
   end

   // The soft-reset bit clears itself after one cycle so it acts as a pulse.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         ctrl <= `SSD_CTRL_RESET;
      else if (busDone && avs_write && avs_address == 5'(`SSD_OFS_CTRL))
         ctrl <= avs_writedata[2:0];
      else
         ctrl[`SSD_CTRL_SOFTRST] <= 1'b0;
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         swAddr  <= `SSD_SWADDR_RESET;
         irqMask <= 5'h00;
      end
      else if (busDone && avs_write)
      begin
         if (avs_address == 5'(`SSD_OFS_SWADDR))
            swAddr <= avs_writedata[7:0];
         if (avs_address == `SSD_ALT_MASK_ADDR)
            irqMask <= avs_writedata[4:0];
      end
   end

   // A reset cannot load a port, so the switches are caught on the first edge after release.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         takeSwitch <= 1'b1;
      else
         takeSwitch <= ctrl[`SSD_CTRL_SOFTRST];
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         sampledSw <= 8'h00;
      else if (takeSwitch)
         sampledSw <= {addrSwitchHigh, addrSwitchLow}; // [R01] [R02] [R05]
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         ipOctet <= 8'h00;
      else if (!ctrl[`SSD_CTRL_SRC])
         ipOctet <= sampledSw; // [R03]
      else
         ipOctet <= swAddr; // [R04]
   end

   logic [2:0] prevNet;
   logic       prevAlarm;
   logic       prevWarn;
   logic [4:0] rise;

   assign rise = {netState != prevNet,
                  networkPortBLink != prevIn[1],
                  networkPortALink != prevIn[0],
                  warningActive && !prevWarn,
                  alarmActive && !prevAlarm};

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         prevIn    <= 5'h00;
         prevNet   <= 3'h0;
         prevAlarm <= 1'b0;
         prevWarn  <= 1'b0;
      end
      else
      begin
         prevIn    <= {netState, networkPortBLink, networkPortALink};
         prevNet   <= netState;
         prevAlarm <= alarmActive;
         prevWarn  <= warningActive;
      end
   end

   // A new event in the same cycle as the clearing read stays set.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         irqStat <= 5'h00;
      else if (busDone && avs_read && avs_address == 5'(`SSD_OFS_IRQSTAT))
         irqStat <= rise;
      else
         irqStat <= irqStat | rise;
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         irq <= 1'b0;
      else
         irq <= |(irqStat & irqMask);
   end

   always_comb
   begin
      next_view = view;
      case (view)
         SSD_BOOT:  if (startupDone) next_view = SSD_NET; // [R07]
         SSD_NET:   if (dwellTick && (alarmActive || warningActive)) next_view = SSD_ALARM; // [R08]
         SSD_ALARM: if (dwellTick || !(alarmActive || warningActive)) next_view = SSD_NET;
         default:   next_view = SSD_BOOT;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         view <= SSD_BOOT;
      else
         view <= next_view;
   end

   logic [6:0] netGlyph;
   logic       linked;
   logic       dotOn;

   assign linked = (netState == SSD_NS_LINKED);
   assign dotOn  = servoOn ? servoReady : (servoReady && blinkPhase);

   always_comb
   begin
      netGlyph = `SSD_GLY_ABSENT;
      if (cpuError)               netGlyph = `SSD_GLY_CPUERR; // [R11]
      else if (fwUpdating)        netGlyph = `SSD_GLY_UPDATE;
      else if (testMode)          netGlyph = `SSD_GLY_TEST;
      else if (initInProgress)    netGlyph = `SSD_GLY_INIT;
      else if (addrSetInProgress) netGlyph = `SSD_GLY_ADDRSET;
      else if (linked)            netGlyph = `SSD_GLY_CONNECTED;
      else if (ctrl[`SSD_CTRL_TSN])
      begin
         case (netState) // [R09]
            SSD_NS_INITCOMM: netGlyph = `SSD_GLY_INITCOMM;
            SSD_NS_PREOP:    netGlyph = `SSD_GLY_PREOP;
            SSD_NS_SAFEOP:   netGlyph = `SSD_GLY_SAFEOP;
            SSD_NS_RESERVED: netGlyph = `SSD_GLY_RESERVED;
            default:         netGlyph = `SSD_GLY_ABSENT;
         endcase
      end
      else
         netGlyph = `SSD_GLY_ABSENT; // [R10]
   end

   // Unused digits of the one-digit variant stay dark.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         segDigit0 <= 8'h00;
         segDigit1 <= 8'h00;
         segDigit2 <= 8'h00;
      end
      else
      begin
         case (view)
            SSD_NET:
            begin
               segDigit0 <= {linked && dotOn, netGlyph}; // [R16]
               segDigit1 <= THREE_DIGIT ? {1'b0, hexGlyph(ipOctet[7:4])} : 8'h00; // [R17]
               segDigit2 <= THREE_DIGIT ? {1'b0, hexGlyph(ipOctet[3:0])} : 8'h00; // [R06]
            end
            SSD_ALARM:
            begin
               segDigit0 <= THREE_DIGIT ? {1'b0, hexGlyph(alarmCode[11:8])}
                                        : {1'b0, `SSD_GLY_ALARM};
               segDigit1 <= THREE_DIGIT ? {1'b0, hexGlyph(alarmCode[7:4])} : 8'h00;
               segDigit2 <= THREE_DIGIT ? {1'b0, hexGlyph(alarmCode[3:0])} : 8'h00;
            end
            default:
            begin
               segDigit0 <= {1'b0, `SSD_GLY_BOOT};
               segDigit1 <= 8'h00;
               segDigit2 <= 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         servoIndicator     <= 1'b0;
         runIndicator       <= 1'b0;
         errorIndicator     <= 1'b0;
         portALinkIndicator <= 1'b0;
         portBLinkIndicator <= 1'b0;
      end
      else
      begin
         servoIndicator     <= dotOn; // [R12]
         runIndicator       <= !alarmActive; // [R13]
         errorIndicator     <= alarmActive || (warningActive && blinkPhase); // [R14]
         portALinkIndicator <= networkPortALink; // [R15]
         portBLinkIndicator <= networkPortBLink;
      end
   end

   a_run_off_alarm: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R13]
      alarmActive |=> !runIndicator) else $error("Run LED lit during alarm.");
   a_err_alarm_on: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R14]
      alarmActive |=> errorIndicator) else $error("Error LED dark during alarm.");
   a_err_quiet: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R14]
      !alarmActive && !warningActive |=> !errorIndicator) else $error("Error LED lit idle.");
   a_servo_steady: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R12]
      servoReady && servoOn |=> servoIndicator) else $error("Servo LED not steady.");
   a_servo_off: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R12]
      !servoReady |=> !servoIndicator) else $error("Servo LED lit when not ready.");
   a_link_follow: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R15]
      ##1 portALinkIndicator == $past(networkPortALink)) else $error("Port A LED wrong.");
   a_boot_hold: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R07]
      view == SSD_BOOT && !startupDone |=> view == SSD_BOOT) else $error("Left boot early.");
   a_addr_hold: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R02]
      !takeSwitch |=> $stable(sampledSw)) else $error("Switch value changed in operation.");
   a_addr_src: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R03]
      !ctrl[`SSD_CTRL_SRC] |=> ipOctet == $past(sampledSw)) else $error("Address not switch.");
   a_basic_absent: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R10]
      view == SSD_NET && !ctrl[`SSD_CTRL_TSN] && !linked && !cpuError && !fwUpdating &&
      !testMode && !initInProgress && !addrSetInProgress
      |=> segDigit0[6:0] == `SSD_GLY_ABSENT) else $error("Basic mode wrong glyph.");
   a_bus_answer: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("Bus request not answered in one cycle.");

   c_alarm_view: cover property (@(posedge clk_sys) disable iff (!rst_b) view == SSD_ALARM);
   c_linked: cover property (@(posedge clk_sys) disable iff (!rst_b)
      view == SSD_NET && linked);
   c_irq: cover property (@(posedge clk_sys) disable iff (!rst_b) irq);

endmodule : ssd_status_display

// ==== ssd_far_model.sv ====
// Purpose: Far side of the block: switch operator and network controller.
// Assumes: Bench requests take effect at the next clock edge.
// Notes:   Switches are mechanical, so they keep their setting through reset.
`timescale 1ns/1ps
module ssd_far_model
   import ssd_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic [7:0] reqSwitch,
   input  wire logic       reqSoftAddr,
   input  wire logic [2:0] reqNet,
   input  wire logic [1:0] reqLink,
   output logic      [3:0] addrSwitchHigh,
   output logic      [3:0] addrSwitchLow,
   output logic      [2:0] netState,
   output logic            linkA,
   output logic            linkB
);
   // Handing the address to software means parking both switches at zero.
   always_ff @(posedge clk_sys)
   begin
      {addrSwitchHigh, addrSwitchLow} <= reqSoftAddr ? 8'h00 : reqSwitch;
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         netState <= SSD_NS_ABSENT;
         {linkB, linkA} <= 2'h0;
      end
      else
      begin
         netState <= reqNet;
         {linkB, linkA} <= reqLink;
      end
   end
endmodule : ssd_far_model

// ==== ssd_status_display_bench.sv ====
// Purpose: Self-checking bench for the status display block.
// Assumes: Short blink and dwell counts; one-digit variant.
// Notes:   Drivers queue expected values; one monitor compares them.
`timescale 1ns/1ps
`include "ssd_map.svh"
module ssd_status_display_bench
   import ssd_pkg::*;
;
   typedef struct {logic [3:0] sel; logic [31:0] mask; logic [31:0] exp;} ssd_note_s;
   localparam logic [4:0] CTRL = 5'h00, SWAD = 5'h04, ADDR = 5'h08, STAT = 5'h0C;
   logic        clk_sys = 1'b0, rst_b = 1'b0;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 1'b0, avs_write = 1'b0, rdChk = 1'b0, probeReq = 1'b0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rnd = 32'h13BB;
   logic        avs_waitrequest, irq, servoIndicator, runIndicator, errorIndicator;
   logic        startupDone = 1'b0, servoReady = 1'b0, servoOn = 1'b0, reqSoftAddr = 1'b0;
   logic        alarmActive = 1'b0, warningActive = 1'b0, linkA, linkB, ledA, ledB;
   logic [4:0]  flags = 5'h00;
   logic [2:0]  reqNet = 3'h0, netState;
   logic [1:0]  reqLink = 2'h0;
   logic [11:0] alarmCode = 12'h000;
   logic [7:0]  reqSwitch = 8'h00, seg0, seg1, seg2, ipOctet, swA, swB, swC;
   logic [3:0]  swHigh, swLow;
   logic [6:0]  gly [11] = '{`SSD_GLY_ABSENT, `SSD_GLY_INITCOMM, `SSD_GLY_PREOP,
      `SSD_GLY_SAFEOP, `SSD_GLY_RESERVED, `SSD_GLY_CPUERR, `SSD_GLY_UPDATE,
      `SSD_GLY_TEST, `SSD_GLY_INIT, `SSD_GLY_ADDRSET, `SSD_GLY_CONNECTED};
   logic [3:0]  ledIn [4] = '{4'h0, 4'h9, 4'hF, 4'h4};
   logic [2:0]  ledBlink [4] = '{3'h0, 3'h7, 3'h1, 3'h0};
   logic [4:0]  ledMask [4] = '{5'h1C, 5'h08, 5'h1C, 5'h1C};
   logic [4:0]  ledExp [4] = '{5'h08, 5'h08, 5'h14, 5'h08};
   ssd_note_s   notes [$];
   int          errors = 0, cmp_count = 0, cycles = 0, togS = 0, togE = 0;
   logic        sawA = 1'b0, prevS = 1'b0, prevE = 1'b0;

   ssd_status_display #(.BLINK_CYC(4), .DWELL_CYC(8)) uut (
      .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .addrSwitchHigh(swHigh), .addrSwitchLow(swLow),
      .startupDone(startupDone), .servoReady(servoReady), .servoOn(servoOn),
      .alarmActive(alarmActive), .warningActive(warningActive), .alarmCode(alarmCode),
      .netState(netState), .testMode(flags[2]), .cpuError(flags[4]),
      .fwUpdating(flags[3]), .initInProgress(flags[1]), .addrSetInProgress(flags[0]),
      .networkPortALink(linkA), .networkPortBLink(linkB), .segDigit0(seg0),
      .segDigit1(seg1), .segDigit2(seg2), .ipOctet(ipOctet), .servoIndicator(servoIndicator),
      .runIndicator(runIndicator), .errorIndicator(errorIndicator),
      .portALinkIndicator(ledA), .portBLinkIndicator(ledB), .irq(irq));

   ssd_far_model far (
      .clk_sys(clk_sys), .rst_b(rst_b), .reqSwitch(reqSwitch), .reqSoftAddr(reqSoftAddr),
      .reqNet(reqNet), .reqLink(reqLink), .addrSwitchHigh(swHigh), .addrSwitchLow(swLow),
      .netState(netState), .linkA(linkA), .linkB(linkB));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   function automatic logic [31:0] obs(input logic [3:0] sel);
      case (sel)
         4'h0: return avs_readdata;
         4'h1: return {24'h0, ipOctet};
         4'h2: return {24'h0, seg0};
         4'h3: return {16'h0, seg2, seg1};
         4'h4: return {27'h0, servoIndicator, runIndicator, errorIndicator, ledA, ledB};
         4'h5: return {31'h0, irq};
         4'h6: return {17'h0, avs_waitrequest, irq, ipOctet, servoIndicator, runIndicator,
                       errorIndicator, ledA, ledB};
         default: return {29'h0, (togS > 1), (togE > 1), sawA};
      endcase
   endfunction : obs

   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude

   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : wt

   task automatic expect_val(input logic [3:0] s, input logic [31:0] m, input logic [31:0] e);
      notes.push_back('{s, m, e});
      probeReq <= 1'b1;
      @(posedge clk_sys);
      probeReq <= 1'b0;
      @(posedge clk_sys);
   endtask : expect_val

   // The request is held until the edge that samples waitrequest low.
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      input logic chk, input logic [31:0] e);
      if (chk)
         notes.push_back('{4'h0, 32'hFFFFFFFF, e});
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      rdChk <= chk;
      do
      begin
         @(posedge clk_sys);
      end
      while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask : bus

   initial
   begin
      forever #12.5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys)
   begin
      ssd_note_s n;
      cycles++;
      togS += (servoIndicator !== prevS);
      togE += (errorIndicator !== prevE);
      prevS = servoIndicator;
      prevE = errorIndicator;
      sawA = sawA | (seg0[6:0] === `SSD_GLY_ALARM);
      if (((avs_read && !avs_waitrequest && rdChk) || probeReq) && notes.size() > 0)
      begin
         n = notes.pop_front();
         cmp_count++;
         if ((obs(n.sel) & n.mask) !== (n.exp & n.mask))
         begin
            errors++;
            $display("unexpected at %0t: item %0d got %h want %h", $time, n.sel,
                     obs(n.sel) & n.mask, n.exp & n.mask);
         end
         togS = 0;
         togE = 0;
         sawA = 1'b0;
      end
      if (cycles == 20000)
      begin
         errors++;
         conclude();
      end
   end

   initial
   begin
      rnd = lfsr_next(rnd);
      swA = rnd[7:0];
      reqSwitch = swA;
      alarmCode = rnd[19:8];
      repeat (8) @(posedge clk_sys);
      expect_val(4'h6, 32'hFFFFFFFF, 32'h00004000);
      rst_b <= 1'b1;
      wt(3);
      bus(1'b0, CTRL, 32'h0, 1'b1, {29'h0, `SSD_CTRL_RESET});
      bus(1'b0, SWAD, 32'h0, 1'b1, {24'h0, `SSD_SWADDR_RESET});
      bus(1'b0, `SSD_ALT_MASK_ADDR, 32'h0, 1'b1, 32'h0);
      bus(1'b1, 5'h14, 32'hFFFFFFFF, 1'b0, 32'h0);
      bus(1'b0, 5'h14, 32'h0, 1'b1, 32'h0);
      expect_val(4'h1, 32'hFF, {24'h0, swA});
      bus(1'b0, ADDR, 32'h0, 1'b1, {16'h0, swA, swA});
      rnd = lfsr_next(rnd);
      swB = swA ^ (rnd[7:0] | 8'h01);
      reqSwitch <= swB;
      wt(4);
      expect_val(4'h1, 32'hFF, {24'h0, swA});
      bus(1'b1, CTRL, 32'h6, 1'b0, 32'h0);
      wt(4);
      expect_val(4'h1, 32'hFF, {24'h0, swB});
      bus(1'b1, CTRL, 32'h5, 1'b0, 32'h0);
      wt(3);
      expect_val(4'h1, 32'hFF, 32'h01);
      rnd = lfsr_next(rnd);
      swC = rnd[7:0];
      bus(1'b1, SWAD, {24'h0, swC}, 1'b0, 32'h0);
      wt(3);
      expect_val(4'h1, 32'hFF, {24'h0, swC});
      reqSoftAddr <= 1'b1;
      bus(1'b1, CTRL, 32'h7, 1'b0, 32'h0);
      wt(4);
      bus(1'b0, ADDR, 32'h0, 1'b1, {16'h0, 8'h00, swC});
      bus(1'b1, CTRL, 32'h4, 1'b0, 32'h0);
      expect_val(4'h2, 32'h7F, `SSD_GLY_BOOT);
      startupDone <= 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         reqNet <= i[2:0];
         wt(5);
         expect_val(4'h2, 32'h7F, {25'h0, gly[i]});
      end
      expect_val(4'h3, 32'hFFFF, 32'h0);
      reqNet <= SSD_NS_LINKED;
      {servoReady, servoOn} <= 2'b11;
      wt(5);
      expect_val(4'h2, 32'hFF, {24'h0, 1'b1, gly[10]});
      servoReady <= 1'b0;
      wt(5);
      expect_val(4'h2, 32'hFF, {24'h0, 1'b0, gly[10]});
      for (int i = 0; i < 5; i++)
      begin
         flags <= 5'h1F >> i;
         wt(5);
         expect_val(4'h2, 32'h7F, {25'h0, gly[5 + i]});
      end
      flags <= 5'h00;
      reqNet <= SSD_NS_PREOP;
      bus(1'b1, CTRL, 32'h0, 1'b0, 32'h0);
      wt(5);
      expect_val(4'h2, 32'h7F, {25'h0, gly[0]});
      bus(1'b1, CTRL, 32'h4, 1'b0, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         {servoReady, servoOn, alarmActive, warningActive} <= ledIn[i];
         wt(12);
         expect_val(4'h7, 32'h0, 32'h0);
         wt(40);
         expect_val(4'h7, 32'h7, {29'h0, ledBlink[i]});
         expect_val(4'h4, {27'h0, ledMask[i]}, {27'h0, ledExp[i]});
      end
      bus(1'b1, `SSD_ALT_MASK_ADDR, 32'h4, 1'b0, 32'h0);
      bus(1'b0, STAT, 32'h0, 1'b0, 32'h0);
      reqLink <= 2'b01;
      wt(4);
      expect_val(4'h4, 32'h3, 32'h2);
      expect_val(4'h5, 32'h1, 32'h1);
      bus(1'b0, STAT, 32'h0, 1'b1, 32'h4);
      wt(3);
      expect_val(4'h5, 32'h1, 32'h0);
      reqLink <= 2'b11;
      wt(4);
      expect_val(4'h4, 32'h3, 32'h3);
      expect_val(4'h5, 32'h1, 32'h0);
      bus(1'b0, STAT, 32'h0, 1'b1, 32'h8);
      conclude();
   end
endmodule : ssd_status_display_bench
